// >>> src/sspm_map.svh
// Register offsets, field positions, codes and reset values of the slot signal pin mux.
`ifndef SSPM_MAP_SVH
`define SSPM_MAP_SVH
`define SSPM_OFF_SEL_B      8'hBE
`define SSPM_OFF_SEL_C      8'hC0
`define SSPM_OFF_DATA       8'hC4
`define SSPM_SEL_RESET      16'h0000
`define SSPM_DATA_RESET     10'h000
`define SSPM_RSVD_BIT       15
`define SSPM_CODE_GP_IN     3'h0
`define SSPM_CODE_GP_OUT    3'h1
`define SSPM_FIELD_W        3
`define SSPM_NUM_PINS       10
`define SSPM_DATA_LSB       5
`endif

// >>> src/sspm_pkg.sv
// Types shared by the slot signal pin mux files.
package sspm_pkg;
  // Slot functions that a pin can carry, indexed by port 0..2 (ports 1..3).
  typedef enum logic [3:0] {
    SSPM_FN_GP_IN,
    SSPM_FN_GP_OUT,
    SSPM_FN_INTERLOCK_CTL,
    SSPM_FN_ATTN_IND,
    SSPM_FN_PWR_IND,
    SSPM_FN_ACT_IND,
    SSPM_FN_BUTTON,
    SSPM_FN_PWR_FAULT,
    SSPM_FN_INTERLOCK_ENG,
    SSPM_FN_CLK_REQ,
    SSPM_FN_LATCH,
    SSPM_FN_PWR_ENABLE,
    SSPM_FN_PRESENCE,
    SSPM_FN_PWR_OK
  } sspm_fn_t;

  typedef struct packed {
    sspm_fn_t   fn;
    logic [1:0] port;
  } sspm_route_t;
endpackage : sspm_pkg

// >>> src/sspm_decode.sv
// Decoder from one pin's selector code and strap state to its slot function.
`timescale 1ns/1ps
`include "sspm_map.svh"
module sspm_decode
  import sspm_pkg::*;
#(
  parameter int PIN = 5
) (
  input  wire logic [2:0]  sel,          // Selector field of this pin.
  input  wire logic        strap_p2,     // Port-2 strap captured at reset release.
  input  wire logic        strap_p3,     // Port-3 strap captured at reset release.
  output sspm_route_t      route         // Function and port driven on the pin.
);
  // Strap dedication beats the selector; otherwise a per-pin code table applies.
  always_comb begin
    route = '{fn: SSPM_FN_GP_IN, port: 2'h0};
    if (sel == `SSPM_CODE_GP_OUT) begin
      route.fn = SSPM_FN_GP_OUT;
    end
    unique case (PIN)
      5: begin
        if (sel[2] | sel[1]) begin
          route.fn   = (sel[2:1] == 2'h1) ? SSPM_FN_INTERLOCK_CTL :
                       (sel[2:1] == 2'h2) ? SSPM_FN_ATTN_IND : SSPM_FN_PWR_IND;
          route.port = sel[0] ? 2'h2 : 2'h0;
        end
        if (strap_p2) route = '{fn: SSPM_FN_PWR_ENABLE, port: 2'h2};
      end
      6: begin
        if (sel[2] | sel[1]) begin
          route.fn   = (sel[2:1] == 2'h1) ? SSPM_FN_BUTTON :
                       (sel[2:1] == 2'h2) ? SSPM_FN_PWR_FAULT : SSPM_FN_LATCH;
          route.port = sel[0] ? 2'h2 : 2'h0;
        end
        if (strap_p2) route = '{fn: SSPM_FN_PWR_OK, port: 2'h2};
      end
      7: begin
        unique case (sel)
          3'h2: route = '{fn: SSPM_FN_CLK_REQ,   port: 2'h1};
          3'h3: route = '{fn: SSPM_FN_LATCH,     port: 2'h1};
          3'h4: route = '{fn: SSPM_FN_PWR_FAULT, port: 2'h0};
          3'h5: route = '{fn: SSPM_FN_PWR_FAULT, port: 2'h2};
          3'h6: route = '{fn: SSPM_FN_LATCH,     port: 2'h0};
          3'h7: route = '{fn: SSPM_FN_LATCH,     port: 2'h2};
          default: ;
        endcase
      end
      8: begin
        if (sel[2] | sel[1]) begin
          route.fn   = (sel[2:1] == 2'h1) ? SSPM_FN_BUTTON :
                       (sel[2:1] == 2'h2) ? SSPM_FN_PWR_FAULT : SSPM_FN_INTERLOCK_ENG;
          route.port = sel[0] ? 2'h1 : 2'h0;
        end
        if (strap_p3) route = '{fn: SSPM_FN_PRESENCE, port: 2'h2};
      end
      9: begin
        if (sel[2] | sel[1]) begin
          route.fn   = (sel[2:1] == 2'h1) ? SSPM_FN_INTERLOCK_CTL :
                       (sel[2:1] == 2'h2) ? SSPM_FN_ATTN_IND : SSPM_FN_PWR_IND;
          route.port = sel[0] ? 2'h1 : 2'h0;
        end
        if (strap_p3) route = '{fn: SSPM_FN_PWR_ENABLE, port: 2'h2};
      end
      10: begin
        if (sel[2] | sel[1]) begin
          route.fn   = (sel[2:1] == 2'h1) ? SSPM_FN_BUTTON :
                       (sel[2:1] == 2'h2) ? SSPM_FN_PWR_FAULT : SSPM_FN_LATCH;
          route.port = sel[0] ? 2'h1 : 2'h0;
        end
        if (strap_p3) route = '{fn: SSPM_FN_PWR_OK, port: 2'h2};
      end
      11: begin
        unique case (sel)
          3'h2: route = '{fn: SSPM_FN_CLK_REQ,   port: 2'h2};
          3'h3: route = '{fn: SSPM_FN_LATCH,     port: 2'h2};
          3'h4: route = '{fn: SSPM_FN_PWR_FAULT, port: 2'h0};
          3'h5: route = '{fn: SSPM_FN_PWR_FAULT, port: 2'h1};
          3'h6: route = '{fn: SSPM_FN_LATCH,     port: 2'h0};
          3'h7: route = '{fn: SSPM_FN_LATCH,     port: 2'h1};
          default: ;
        endcase
      end
      default: begin
        // Pins 12 to 14 share activity indicators on codes 2 to 4.
        if (sel >= 3'h2 && sel <= 3'h4) begin
          route = '{fn: SSPM_FN_ACT_IND, port: 2'(sel - 3'h2)};
        end
        unique case (sel)
          // Typed patterns: an untyped pattern inside a conditional has no target type.
          3'h5: route = (PIN == 13) ? sspm_route_t'{fn: SSPM_FN_ATTN_IND, port: 2'h0} :
                                      sspm_route_t'{fn: SSPM_FN_PWR_IND,  port: 2'h0};
          3'h6: route = (PIN == 12) ? sspm_route_t'{fn: SSPM_FN_ATTN_IND, port: 2'h1} :
                                      sspm_route_t'{fn: SSPM_FN_PWR_IND,  port: 2'h1};
          3'h7: route = (PIN == 14) ? sspm_route_t'{fn: SSPM_FN_PWR_FAULT, port: 2'h2} :
                        (PIN == 13) ? sspm_route_t'{fn: SSPM_FN_PWR_IND,   port: 2'h2} :
                                      sspm_route_t'{fn: SSPM_FN_ATTN_IND,  port: 2'h2};
          default: ;
        endcase
      end
    endcase
  end
endmodule : sspm_decode

// >>> src/sspm_pin_mux.sv
// Pin function multiplexer for ten multifunction slot signal pins.
//
// Contract
// - Pin 9 selector at B[14:12]: input, output, interlock/attention/power LED ports 1,2.
// - Pin 8 selector at B[11:9]: button, power fault, interlock engage ports 1,2.
// - Pin 7 selector at B[8:6]: clock request, latch sensors, power faults.
// - Pin 6 selector at B[5:3]: button, fault, latch alternating ports 1 and 3.
// - Pin 5 selector at B[2:0]: interlock, attention, power LED ports 1 and 3.
// - Port-3 strap high at reset release makes pin 9 port-3 power enable.
// - Port-3 strap high makes pin 8 the port-3 presence input.
// - Port-2 strap high makes pin 6 the port-3 power-ok input.
// - Port-2 strap high makes pin 5 the port-3 power enable output.
// - Port-3 strap high makes pin 10 the port-3 power-ok input.
// - Strap vector bit 1 set makes pins 6 and 5 selectors read-only zero.
// - Bit 15 of both selector registers reads zero.
// - Register C at offset C0h is read/write, resets to zero.
// - Pin 14 selector at C[14:12]: activity, power LEDs, port-3 power fault.
// - Pin 13 selector at C[11:9]: activity, port-1 attention, power LEDs 2,3.
// - Pin 12 selector at C[8:6]: activity, port-1 power, attention LEDs 2,3.
// - Pin 11 selector at C[5:3]: clock request, latch sensors, power faults.
// - Pin 10 selector at C[2:0]: button, fault, latch alternating ports 1,2.
// - Fundamental reset clears selectors; EEPROM load follows when present.
// - Data writes change only pins selected as general output.
// - Output mode data drives pin and reads back; input mode ignores writes.
`timescale 1ns/1ps
`include "sspm_map.svh"
module sspm_pin_mux
  import sspm_pkg::*;
(
  input  wire logic        clk_sys,          // System clock, 200 MHz.
  input  wire logic        reset,            // Asynchronous fundamental reset, active high.
  input  wire logic        port2_slot_strap, // Port-2 strap level, caught at reset release.
  input  wire logic        port3_slot_strap, // Port-3 strap level, caught at reset release.
  input  wire logic [1:0]  slot_strap_vector,// Strap vector, bit 1 locks pins 5 and 6.
  input  wire logic        cfg_wr,           // Configuration write strobe, one cycle.
  input  wire logic        cfg_rd,           // Configuration read strobe, one cycle.
  input  wire logic [7:0]  cfg_addr,         // Configuration byte offset.
  input  wire logic [15:0] cfg_wdata,        // Configuration write data.
  input  wire logic        ee_load,          // EEPROM load strobe, one cycle.
  input  wire logic [7:0]  ee_addr,          // EEPROM load target offset.
  input  wire logic [15:0] ee_data,          // EEPROM load data.
  input  wire logic [9:0]  pin_in,           // Pin levels of pins 5..14, bit 0 is pin 5.
  output logic [15:0]      cfg_rdata,        // Read data, valid the cycle after cfg_rd.
  output logic             cfg_rvalid,       // Read data valid pulse.
  output logic [9:0]       pin_out,          // Pin output levels.
  output logic [9:0]       pin_oe,           // Pin output enables, high while driven.
  output sspm_route_t [9:0] pin_route        // Function carried by each pin.
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0]       sel_b;
    logic [15:0]       sel_c;
    logic [9:0]        data;
    logic              strap_p2;
    logic              strap_p3;
    logic              lock56;
    logic              strap_taken;
    logic [15:0]       rdata;
    logic              rvalid;
    logic [9:0]        out;
    logic [9:0]        oe;
    sspm_route_t [9:0] route;
  } sspm_state_t;

  sspm_state_t  st_ff;
  sspm_state_t  nxt_st;
  logic [29:0]  sel_flat;
  sspm_route_t [9:0] route_w;

  // ------------------------------------------------------------------
  // Per-pin decode
  // ------------------------------------------------------------------
  // The decoders look at the stored selectors, so a write lands on routing one cycle after the selector register, two edges after the strobe.
  assign sel_flat = {st_ff.sel_c[14:0], st_ff.sel_b[14:0]};

  genvar gi;
  generate
    for (gi = 0; gi < `SSPM_NUM_PINS; gi++) begin : g_pin
      sspm_decode #(.PIN(gi + `SSPM_DATA_LSB)) u_dec (
        .sel      (sel_flat[gi*3 +: 3]),
        .strap_p2 (st_ff.strap_p2),
        .strap_p3 (st_ff.strap_p3),
        .route    (route_w[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  // Register writes, EEPROM loads, data writes, readback and pin drive.
  always_comb begin
    logic [9:0]  gp_out;
    logic [15:0] wv;
    logic [7:0]  wa;
    logic        we;
    logic        lock_now;
    gp_out = '0;
    wv     = '0;
    wa     = '0;
    we     = 1'b0;
    lock_now = 1'b0;
    nxt_st = st_ff;
    // Straps are caught once, on the first edge after reset release.
    if (!st_ff.strap_taken) begin
      nxt_st.strap_p2    = port2_slot_strap;
      nxt_st.strap_p3    = port3_slot_strap;
      nxt_st.lock56      = slot_strap_vector[1];
      nxt_st.strap_taken = 1'b1;
    end
    // On the catching edge the lock is taken from the pin, so a write there cannot slip past.
    lock_now = st_ff.strap_taken ? st_ff.lock56 : slot_strap_vector[1];
    for (int i = 0; i < `SSPM_NUM_PINS; i++) begin
      gp_out[i] = (route_w[i].fn == SSPM_FN_GP_OUT);
    end
    // EEPROM load and software write share one path; the load wins a collision.
    we = ee_load | cfg_wr;
    wa = ee_load ? ee_addr : cfg_addr;
    wv = ee_load ? ee_data : cfg_wdata;
    if (we && wa == `SSPM_OFF_SEL_B) begin
      nxt_st.sel_b = {1'b0, wv[14:0]};
      if (lock_now) nxt_st.sel_b[5:0] = 6'h00;
    end
    if (we && wa == `SSPM_OFF_SEL_C) begin
      nxt_st.sel_c = {1'b0, wv[14:0]};
    end
    if (we && wa == `SSPM_OFF_DATA) begin
      // Only general output pins take the new bit.
      for (int i = 0; i < `SSPM_NUM_PINS; i++) begin
        if (gp_out[i]) nxt_st.data[i] = wv[i + `SSPM_DATA_LSB];
      end
    end
    // Readback.
    nxt_st.rvalid = cfg_rd;
    nxt_st.rdata  = '0;
    if (cfg_rd) begin
      unique case (cfg_addr)
        `SSPM_OFF_SEL_B: nxt_st.rdata = st_ff.sel_b;
        `SSPM_OFF_SEL_C: nxt_st.rdata = st_ff.sel_c;
        `SSPM_OFF_DATA: begin
          for (int i = 0; i < `SSPM_NUM_PINS; i++) begin
            // Output pins show the driven bit; all others show the pin level.
            nxt_st.rdata[i + `SSPM_DATA_LSB] = gp_out[i] ? st_ff.data[i] : pin_in[i];
          end
        end
        default: nxt_st.rdata = '0;
      endcase
    end
    // Pin drive: general outputs drive their data bit, slot outputs are routed out.
    for (int i = 0; i < `SSPM_NUM_PINS; i++) begin
      nxt_st.route[i] = route_w[i];
      nxt_st.oe[i]    = gp_out[i] | (route_w[i].fn inside {SSPM_FN_INTERLOCK_CTL,
                        SSPM_FN_ATTN_IND, SSPM_FN_PWR_IND, SSPM_FN_ACT_IND,
                        SSPM_FN_PWR_ENABLE});
      nxt_st.out[i]   = gp_out[i] & st_ff.data[i];
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Fundamental reset clears all selectors and data; straps re-caught after release.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cfg_rdata  = st_ff.rdata;
  assign cfg_rvalid = st_ff.rvalid;
  assign pin_out    = st_ff.out;
  assign pin_oe     = st_ff.oe;
  assign pin_route  = st_ff.route;

endmodule : sspm_pin_mux

// >>> verif/sspm_pin_mux_checker.sv
// Port-level assertions for the slot signal pin mux.
`timescale 1ns/1ps
module sspm_pin_mux_checker
  import sspm_pkg::*;
(
  input wire logic        clk_sys,           // System clock.
  input wire logic        reset,             // Fundamental reset.
  input wire logic        port2_slot_strap,  // Port-2 strap.
  input wire logic        port3_slot_strap,  // Port-3 strap.
  input wire logic [1:0]  slot_strap_vector, // Strap vector.
  input wire logic        cfg_wr,            // Write strobe.
  input wire logic        cfg_rd,            // Read strobe.
  input wire logic [7:0]  cfg_addr,          // Offset.
  input wire logic [15:0] cfg_wdata,         // Write data.
  input wire logic        ee_load,           // Load strobe.
  input wire logic [15:0] cfg_rdata,         // Read data.
  input wire logic        cfg_rvalid,        // Read valid.
  input wire logic [9:0]  pin_out,           // Pin levels.
  input wire logic [9:0]  pin_oe,            // Pin enables.
  input wire sspm_route_t [9:0] pin_route    // Pin routing.
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic [1:0] rel_ff;
  logic [1:0] nxt_rel;
  logic [9:0] gp_out_v;

  // Strap routing is only judged from the fourth edge after release, once it settled.
  always_comb begin
    nxt_rel = (rel_ff == 2'h3) ? rel_ff : rel_ff + 2'h1;
    for (int i = 0; i < 10; i++) begin
      gp_out_v[i] = (pin_route[i].fn == SSPM_FN_GP_OUT);
    end
  end

  // Edge counter since reset release.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rel_ff <= 2'h0;
    end else begin
      rel_ff <= nxt_rel;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence sel9_out;
    cfg_wr && !ee_load && cfg_addr == 8'hBE && cfg_wdata[14:12] == 3'h1
      && !port3_slot_strap ##1 !cfg_wr && !ee_load;
  endsequence

  sequence rd_locked;
    cfg_rd && cfg_addr == 8'hBE && slot_strap_vector[1] ##1 cfg_rvalid;
  endsequence

  rd_answer_a: assert property (cfg_rd |=> cfg_rvalid)
    else $error("read strobe not answered");
  rd_idle_a: assert property (!cfg_rvalid |-> cfg_rdata == 16'h0000)
    else $error("read data outside valid cycle");
  rsvd_zero_a: assert property (cfg_rvalid |-> !cfg_rdata[15])
    else $error("reserved bit read as one");
  sel_reach_a: assert property (sel9_out |=> pin_route[4].fn == SSPM_FN_GP_OUT && pin_oe[4])
    else $error("selector write did not reach pin routing");
  lock_zero_a: assert property (rd_locked |-> cfg_rdata[5:0] == 6'h00)
    else $error("locked selectors read nonzero");
  strap3_pins_a: assert property (rel_ff == 2'h3 && port3_slot_strap |->
    pin_route[4] == {SSPM_FN_PWR_ENABLE, 2'h2} && pin_oe[4]
    && pin_route[3] == {SSPM_FN_PRESENCE, 2'h2} && pin_route[5] == {SSPM_FN_PWR_OK, 2'h2})
    else $error("port-3 strap routing wrong");
  strap2_pins_a: assert property (rel_ff == 2'h3 && port2_slot_strap |->
    pin_route[1] == {SSPM_FN_PWR_OK, 2'h2} && !pin_oe[1]
    && pin_route[0] == {SSPM_FN_PWR_ENABLE, 2'h2})
    else $error("port-2 strap routing wrong");
  out_gp_a: assert property ((pin_out & ~gp_out_v) == 10'h000)
    else $error("data reached a pin not in output mode");
  in_quiet_a: assert property (pin_route[0].fn == SSPM_FN_GP_IN |-> !pin_oe[0])
    else $error("input pin driven");
endmodule : sspm_pin_mux_checker

bind sspm_pin_mux sspm_pin_mux_checker sspm_pin_mux_checker_i (
  .clk_sys(clk_sys), .reset(reset), .port2_slot_strap(port2_slot_strap),
  .port3_slot_strap(port3_slot_strap), .slot_strap_vector(slot_strap_vector),
  .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
  .ee_load(ee_load), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_route(pin_route));

// >>> verif/sspm_slot_model.sv
// Slot-side parts on the ten pins: switches, indicators and sensors.
`timescale 1ns/1ps
module sspm_slot_model (
  input  wire logic [9:0] pin_out, // Levels the mux drives.
  input  wire logic [9:0] pin_oe,  // Mux driver enables.
  input  wire logic [9:0] sense,   // Levels the slot parts present.
  output logic      [9:0] pin_in   // Resolved pin levels.
);
  // A driven pin shows the mux level, an undriven one the slot part's level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & sense);
endmodule : sspm_slot_model

// >>> verif/sspm_pin_mux_tb.sv
// Self-checking testbench for the slot signal pin mux.
`timescale 1ns/1ps
module sspm_pin_mux_tb;
  import sspm_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic port2_slot_strap = 1'b0, port3_slot_strap = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic ee_load = 1'b0;
  logic [1:0] slot_strap_vector = 2'h0;
  logic [7:0] cfg_addr = 8'h00, ee_addr = 8'h00;
  logic [15:0] cfg_wdata = 16'h0000, ee_data = 16'h0000, cfg_rdata;
  logic cfg_rvalid;
  logic [9:0] pin_in, pin_out, pin_oe;
  logic [9:0] sense = 10'h000;
  sspm_route_t [9:0] pin_route;
  int errors = 0, n_compared = 0;

  always #2.5 clk_sys = ~clk_sys;

  sspm_pin_mux sspm_pin_mux_i (.clk_sys(clk_sys), .reset(reset),
    .port2_slot_strap(port2_slot_strap), .port3_slot_strap(port3_slot_strap),
    .slot_strap_vector(slot_strap_vector), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .ee_load(ee_load), .ee_addr(ee_addr),
    .ee_data(ee_data), .pin_in(pin_in), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_route(pin_route));
  sspm_slot_model sspm_slot_model_i (.pin_out(pin_out), .pin_oe(pin_oe),
    .sense(sense), .pin_in(pin_in));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Inputs change 1 ns after an edge so no race with the design's sampling.
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    step(1);
    cfg_wr = 1'b0;
    // An idle edge keeps a following request from reassigning the strobe in this step.
    step(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    cfg_addr = a;
    cfg_rd = 1'b1;
    step(1);
    cfg_rd = 1'b0;
    check({15'h0, cfg_rvalid}, 16'h0001);
    check(cfg_rdata, exp);
    step(1);
  endtask : rd
  task automatic rt(input int i, input sspm_fn_t f, input logic [1:0] p);
    check({10'h0, pin_route[i]}, {10'h0, f, p});
  endtask : rt
  // Straps stay fixed for the whole reset period, as the hardware samples them at release.
  task automatic do_reset(input logic p2, input logic p3, input logic v1);
    reset = 1'b1;
    port2_slot_strap = p2;
    port3_slot_strap = p3;
    slot_strap_vector = {v1, 1'b0};
    step(12);
    reset = 1'b0;
    step(3);
  endtask : do_reset
  task automatic results;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_access;
    rd(8'hBE, 16'h0000);
    rd(8'hC0, 16'h0000);
    rd(8'h10, 16'h0000);
    wr(8'hC0, 16'hFFFF);
    rd(8'hC0, 16'h7FFF);
    wr(8'hBE, 16'hFFFF);
    rd(8'hBE, 16'h7FFF);
  endtask : t_access
  task automatic t_codes;
    sspm_fn_t f9 [8] = '{SSPM_FN_GP_IN, SSPM_FN_GP_OUT, SSPM_FN_INTERLOCK_CTL,
      SSPM_FN_INTERLOCK_CTL, SSPM_FN_ATTN_IND, SSPM_FN_ATTN_IND, SSPM_FN_PWR_IND, SSPM_FN_PWR_IND};
    sspm_fn_t f10 [8] = '{SSPM_FN_GP_IN, SSPM_FN_GP_OUT, SSPM_FN_BUTTON, SSPM_FN_BUTTON,
      SSPM_FN_PWR_FAULT, SSPM_FN_PWR_FAULT, SSPM_FN_LATCH, SSPM_FN_LATCH};
    sspm_fn_t f14 [8] = '{SSPM_FN_GP_IN, SSPM_FN_GP_OUT, SSPM_FN_ACT_IND, SSPM_FN_ACT_IND,
      SSPM_FN_ACT_IND, SSPM_FN_PWR_IND, SSPM_FN_PWR_IND, SSPM_FN_PWR_FAULT};
    sspm_fn_t f8 [8] = '{SSPM_FN_GP_IN, SSPM_FN_GP_OUT, SSPM_FN_BUTTON, SSPM_FN_BUTTON,
      SSPM_FN_PWR_FAULT, SSPM_FN_PWR_FAULT, SSPM_FN_INTERLOCK_ENG, SSPM_FN_INTERLOCK_ENG};
    sspm_fn_t f7 [8] = '{SSPM_FN_GP_IN, SSPM_FN_GP_OUT, SSPM_FN_CLK_REQ, SSPM_FN_LATCH,
      SSPM_FN_PWR_FAULT, SSPM_FN_PWR_FAULT, SSPM_FN_LATCH, SSPM_FN_LATCH};
    sspm_fn_t f12 [8] = '{SSPM_FN_GP_IN, SSPM_FN_GP_OUT, SSPM_FN_ACT_IND, SSPM_FN_ACT_IND,
      SSPM_FN_ACT_IND, SSPM_FN_PWR_IND, SSPM_FN_ATTN_IND, SSPM_FN_ATTN_IND};
    sspm_fn_t f13 [8] = '{SSPM_FN_GP_IN, SSPM_FN_GP_OUT, SSPM_FN_ACT_IND, SSPM_FN_ACT_IND,
      SSPM_FN_ACT_IND, SSPM_FN_ATTN_IND, SSPM_FN_PWR_IND, SSPM_FN_PWR_IND};
    logic [1:0] p14 [8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2};
    logic [1:0] p7 [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h2, 2'h0, 2'h2};
    logic [1:0] p11 [8] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h0, 2'h1, 2'h0, 2'h1};
    logic [7:0] odd = 8'hA8;
    for (int c = 0; c < 8; c++) begin
      wr(8'hBE, {1'b0, {5{c[2:0]}}});
      wr(8'hC0, {1'b0, {5{c[2:0]}}});
      step(2);
      rt(3, f8[c], {1'b0, odd[c]});
      rt(2, f7[c], p7[c]);
      rt(6, f7[c], p11[c]);
      rt(7, f12[c], p14[c]);
      rt(8, f13[c], p14[c]);
      check({15'h0, pin_oe[3]}, {15'h0, c == 1});
      rt(4, f9[c], {1'b0, odd[c]});
      rt(0, f9[c], {odd[c], 1'b0});
      rt(1, f10[c], {odd[c], 1'b0});
      rt(5, f10[c], {1'b0, odd[c]});
      rt(9, f14[c], p14[c]);
      check({15'h0, pin_oe[4]}, {15'h0, c != 0});
    end
  endtask : t_codes
  task automatic t_data;
    wr(8'hC0, 16'h0001);
    wr(8'hBE, 16'h1001);
    step(1);
    wr(8'hC4, 16'h7FE0);
    step(1);
    check({6'h0, pin_out}, 16'h0031);
    // Input pins show the slot level, output pins their stored bit.
    sense = 10'h2AA;
    rd(8'hC4, 16'h5760);
    // Pin 6 turned to output must show that the earlier data write skipped it.
    wr(8'hBE, 16'h1009);
    step(1);
    check({6'h0, pin_out}, 16'h0031);
    wr(8'hC4, 16'h0000);
    step(1);
    check({6'h0, pin_out}, 16'h0000);
  endtask : t_data
  task automatic t_eeprom;
    ee_addr = 8'hC0;
    ee_data = 16'h0005;
    ee_load = 1'b1;
    cfg_addr = 8'hC0;
    cfg_wdata = 16'h0002;
    cfg_wr = 1'b1;
    step(1);
    ee_load = 1'b0;
    cfg_wr = 1'b0;
    step(1);
    rd(8'hC0, 16'h0005);
  endtask : t_eeprom
  task automatic t_straps;
    do_reset(1'b0, 1'b1, 1'b0);
    rt(4, SSPM_FN_PWR_ENABLE, 2'h2);
    rt(3, SSPM_FN_PRESENCE, 2'h2);
    rt(5, SSPM_FN_PWR_OK, 2'h2);
    wr(8'hBE, 16'h1000);
    step(2);
    rt(4, SSPM_FN_PWR_ENABLE, 2'h2);
    wr(8'hBE, 16'h0000);
    do_reset(1'b1, 1'b0, 1'b1);
    rt(1, SSPM_FN_PWR_OK, 2'h2);
    rt(0, SSPM_FN_PWR_ENABLE, 2'h2);
    wr(8'hBE, 16'h003F);
    rd(8'hBE, 16'h0000);
  endtask : t_straps

  // Watchdog: a run that overstays its cycle budget is a failure.
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    results();
  end

  initial begin
    do_reset(1'b0, 1'b0, 1'b0);
    t_access();
    t_codes();
    t_data();
    t_eeprom();
    t_straps();
    results();
  end
endmodule : sspm_pin_mux_tb
